// [rtl/ewc_pkg.sv]
// Purpose: Constants for the EEPROM write-lock and polling controller
// Assumes: 40 MHz i_mclk, APB register access, 32K x 8 parallel EEPROM
// Notes: Times are kept in ns with derived cycle counts
package ewc_pkg;
  localparam int unsigned CLK_NS = 25;
  localparam logic [14:0] ADDR_CMD_A = 15'h5555;
  localparam logic [14:0] ADDR_CMD_B = 15'h2aaa;
  localparam logic [7:0] DAT_KEY_A = 8'haa;
  localparam logic [7:0] DAT_KEY_B = 8'h55;
  localparam logic [7:0] DAT_SET_LOCK = 8'ha0;
  localparam logic [7:0] DAT_EXT = 8'h80;
  localparam logic [7:0] DAT_CLR_LOCK = 8'h20;
  localparam logic [7:0] DAT_ERASE = 8'h10;
  localparam logic [7:0] DAT_NO_AUTOERASE = 8'h40;
  localparam int unsigned PAGE_BYTES = 64;
  localparam int unsigned PAGE_COL_BITS = 6;
  // Bus timing of one strobe phase and the poll start delay
  localparam int unsigned STROBE_NS = 100;
  localparam int unsigned POLL_DELAY_NS = 500;
  localparam int unsigned STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned POLL_DELAY_CYC = (POLL_DELAY_NS + CLK_NS - 1) / CLK_NS;
  // Register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_DATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_RDATA = 8'h10;
  // Control fields
  localparam int unsigned CTRL_GO = 0;
  localparam int unsigned CTRL_OP_LSB = 1;
  localparam int unsigned CTRL_OP_W = 3;
  localparam int unsigned CTRL_LAST = 4;
  // Status fields
  localparam int unsigned ST_BUSY = 0;
  localparam int unsigned ST_DONE = 1;
  localparam int unsigned ST_POLL_OK = 2;
  localparam int unsigned ST_LOCKED = 3;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  typedef enum logic [2:0] {
    OP_READ,
    OP_WRITE,
    OP_LOCKED_WRITE,
    OP_SET_LOCK,
    OP_CLEAR_LOCK,
    OP_CHIP_ERASE,
    OP_NO_AUTOERASE,
    OP_POLL
  } ewc_op_t;
endpackage

// [rtl/ewc_bus_if.sv]
// Purpose: Pin cycle request/answer between sequencer and pin engine
// Assumes: One request outstanding at a time
// Notes: Engine answers with a one-cycle done pulse
`timescale 1ns/1ps
interface ewc_bus_if;
  logic req;
  logic wr;
  logic [14:0] addr;
  logic [7:0] wdata;
  logic done;
  logic [7:0] rdata;
  modport seq (output req, output wr, output addr, output wdata, input done, input rdata);
  modport eng (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface

// [rtl/ewc_pin_engine.sv]
// Purpose: Drives one EEPROM read or write cycle on the pins
// Assumes: Device pins are synchronous to i_mclk
// Notes: Only the byte-write pin combination is ever used for writes
`timescale 1ns/1ps
module ewc_pin_engine (
  input wire logic i_mclk,
  input wire logic i_rst,
  ewc_bus_if.eng bus,
  output logic o_ce_n,
  output logic o_oe_n,
  output logic o_we_n,
  output logic [14:0] o_addr,
  output logic [7:0] o_dq,
  output logic o_dq_oe,
  input wire logic [7:0] i_dq
);
  typedef enum logic [1:0] {ENG_IDLE, ENG_SETUP, ENG_STROBE, ENG_HOLD} ewc_eng_t;
  ewc_eng_t state, next_state;
  logic [7:0] cnt, next_cnt;
  logic wr, next_wr;
  logic ce_n, oe_n, we_n, dq_oe, done;
  logic next_ce_n, next_oe_n, next_we_n, next_dq_oe, next_done;
  logic [14:0] addr, next_addr;
  logic [7:0] wdat, next_wdat, rdat, next_rdat;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_wr = wr;
    next_ce_n = ce_n;
    next_oe_n = oe_n;
    next_we_n = we_n;
    next_dq_oe = dq_oe;
    next_done = 1'b0;
    next_addr = addr;
    next_wdat = wdat;
    next_rdat = rdat;
    unique case (state)
      ENG_IDLE: begin
        if (bus.req) begin
          next_wr = bus.wr;
          next_addr = bus.addr;
          next_wdat = bus.wdata;
          next_cnt = 8'(ewc_pkg::STROBE_CYC);
          next_state = ENG_SETUP;
        end
      end
      ENG_SETUP: begin
        // Write: ce low, oe high, we low; read: ce and oe low, we high
        next_ce_n = 1'b0;
        next_oe_n = wr;
        next_we_n = ~wr; // see RULE6
        next_dq_oe = wr;
        next_state = ENG_STROBE;
      end
      ENG_STROBE: begin
        if (cnt == 8'h00) begin
          if (!wr) begin
            next_rdat = i_dq;
          end
          next_we_n = 1'b1;
          next_oe_n = 1'b1;
          next_state = ENG_HOLD;
        end else begin
          next_cnt = cnt - 8'h01;
        end
      end
      ENG_HOLD: begin
        next_ce_n = 1'b1;
        next_dq_oe = 1'b0;
        next_done = 1'b1;
        next_state = ENG_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      state <= ENG_IDLE;
      cnt <= 8'h00;
      wr <= 1'b0;
      ce_n <= 1'b1;
      oe_n <= 1'b1;
      we_n <= 1'b1;
      dq_oe <= 1'b0;
      done <= 1'b0;
      addr <= 15'h0000;
      wdat <= 8'h00;
      rdat <= 8'h00;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      wr <= next_wr;
      ce_n <= next_ce_n;
      oe_n <= next_oe_n;
      we_n <= next_we_n;
      dq_oe <= next_dq_oe;
      done <= next_done;
      addr <= next_addr;
      wdat <= next_wdat;
      rdat <= next_rdat;
    end
  end

  assign o_ce_n = ce_n;
  assign o_oe_n = oe_n;
  assign o_we_n = we_n;
  assign o_addr = addr;
  assign o_dq = wdat;
  assign o_dq_oe = dq_oe;
  assign bus.done = done;
  assign bus.rdata = rdat;
endmodule

// [rtl/ewc_ctrl.sv]
// Purpose: Host controller issuing EEPROM command sequences and polling
// Assumes: APB slave for software, pins synchronous to i_mclk
// Notes: Software loads page bytes one per command; the page ends when the window expires
// Behaviour
// RULE1: While writing, device returns inverted bit seven of last written data.
// RULE2: After the write ends, reading the last address returns true data.
// RULE3: Host waits the poll start delay after the final byte before polling.
// RULE4: Polling mid page load returns inverted bit seven of last loaded byte.
// RULE5: Bit six toggles on each poll read during a write, then stops.
// RULE6: Writes happen only with the byte-write pin combination.
// RULE7: Write lock is off at delivery so plain writes work.
// RULE8: Set lock: AA to 5555, 55 to 2AAA, A0 to 5555, then data.
// RULE9: Device drops a sequence on a wrong step or page timer expiry.
// RULE10: Reads inside a command sequence act as polling reads.
// RULE11: With lock set, every write is preceded by the three-step unlock.
// RULE12: One unlock allows one byte or page load only.
// RULE13: Set sequence alone still sets the lock after the page timer.
// RULE14: Clear lock: AA,55,80,AA,55,20 at 5555/2AAA, then optional data.
// RULE15: Clear sequence alone still clears the lock after the page timer.
// RULE16: Erase and autoerase-disable work locked and unlocked, without data. Code still loads one data byte after the autoerase-disable steps.
// RULE17: Sixth step 10 to 5555 erases the whole array.
// RULE18: Chip erase is accepted only while autoerase is enabled.
// RULE19: Sixth step 40 to 5555 skips erase for the next write only.
// RULE20: Autoerase is enabled on every power-up or reset.
// RULE21: Page load ends after the load window without a new strobe.
// RULE22: Upper page address bits stay constant within one page load.
`timescale 1ns/1ps
module ewc_ctrl #(
  parameter int unsigned POLL_DELAY = ewc_pkg::POLL_DELAY_CYC
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic o_ce_n,
  output logic o_oe_n,
  output logic o_we_n,
  output logic [14:0] o_addr,
  output logic [7:0] o_dq,
  output logic o_dq_oe,
  input wire logic [7:0] i_dq
);
  typedef enum logic [2:0] {
    SQ_IDLE, SQ_PREFIX, SQ_DATA, SQ_WAIT_DELAY, SQ_POLL, SQ_READ
  } ewc_seq_t;

  ewc_bus_if bus ();

  ewc_pin_engine u_eng (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .bus(bus),
    .o_ce_n(o_ce_n),
    .o_oe_n(o_oe_n),
    .o_we_n(o_we_n),
    .o_addr(o_addr),
    .o_dq(o_dq),
    .o_dq_oe(o_dq_oe),
    .i_dq(i_dq)
  );

  ewc_seq_t state, next_state;
  ewc_pkg::ewc_op_t op, next_op;
  logic [2:0] step, next_step;
  logic [2:0] nsteps, next_nsteps;
  logic [31:0] dly, next_dly;
  logic [14:0] addr, next_addr, last_addr, next_last_addr;
  logic [7:0] wdata, next_wdata, last_data, next_last_data, rdata, next_rdata;
  logic busy, next_busy, done, next_done;
  logic poll_ok, next_poll_ok, locked, next_locked;
  logic autoerase_off, next_autoerase_off, prev_b6, next_prev_b6;
  logic req, next_req, wr, next_wr;
  logic [14:0] req_addr, next_req_addr;
  logic [7:0] req_data, next_req_data;
  logic [31:0] prdata_r, next_prdata;
  logic pready_r, next_pready, pslverr_r, next_pslverr;
  logic go;
  logic [14:0] pfx_addr;
  logic [7:0] pfx_data;

  assign go = psel && penable && pwrite && !pready_r && paddr == ewc_pkg::REG_CTRL &&
              pwdata[ewc_pkg::CTRL_GO] && !busy;

  // Prefix table for command steps
  always_comb begin
    pfx_addr = ewc_pkg::ADDR_CMD_A;
    pfx_data = ewc_pkg::DAT_KEY_A;
    unique case (step)
      3'd0, 3'd3: begin
        pfx_addr = ewc_pkg::ADDR_CMD_A;
        pfx_data = ewc_pkg::DAT_KEY_A;
      end
      3'd1, 3'd4: begin
        pfx_addr = ewc_pkg::ADDR_CMD_B;
        pfx_data = ewc_pkg::DAT_KEY_B;
      end
      3'd2: begin
        pfx_addr = ewc_pkg::ADDR_CMD_A;
        pfx_data = (nsteps == 3'd3) ? ewc_pkg::DAT_SET_LOCK : ewc_pkg::DAT_EXT; // see RULE8
      end
      default: begin
        pfx_addr = ewc_pkg::ADDR_CMD_A;
        unique case (op)
          ewc_pkg::OP_CLEAR_LOCK: pfx_data = ewc_pkg::DAT_CLR_LOCK; // see RULE14
          ewc_pkg::OP_CHIP_ERASE: pfx_data = ewc_pkg::DAT_ERASE; // see RULE17
          default: pfx_data = ewc_pkg::DAT_NO_AUTOERASE; // see RULE19
        endcase
      end
    endcase
  end

  always_comb begin
    next_state = state;
    next_op = op;
    next_step = step;
    next_nsteps = nsteps;
    next_dly = dly;
    next_addr = addr;
    next_wdata = wdata;
    next_last_addr = last_addr;
    next_last_data = last_data;
    next_rdata = rdata;
    next_busy = busy;
    next_done = done;
    next_poll_ok = poll_ok;
    next_locked = locked;
    next_autoerase_off = autoerase_off;
    next_prev_b6 = prev_b6;
    next_req = 1'b0;
    next_wr = wr;
    next_req_addr = req_addr;
    next_req_data = req_data;
    next_prdata = prdata_r;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    // APB slave, one wait state
    if (psel && penable && !pready_r) begin
      next_pready = 1'b1;
      if (pwrite) begin
        unique case (paddr)
          ewc_pkg::REG_CTRL: begin
            if (go) begin
              next_op = ewc_pkg::ewc_op_t'(pwdata[ewc_pkg::CTRL_OP_LSB +: ewc_pkg::CTRL_OP_W]);
              next_busy = 1'b1;
              next_done = 1'b0;
              next_step = 3'd0;
              next_state = SQ_PREFIX;
            end
          end
          ewc_pkg::REG_ADDR: next_addr = pwdata[14:0];
          ewc_pkg::REG_DATA: next_wdata = pwdata[7:0];
          ewc_pkg::REG_STATUS: begin
            if (pwdata[ewc_pkg::ST_DONE]) begin
              next_done = 1'b0;
            end
          end
          default: next_pslverr = 1'b1;
        endcase
      end else begin
        unique case (paddr)
          ewc_pkg::REG_CTRL: next_prdata = {29'h0, op};
          ewc_pkg::REG_ADDR: next_prdata = {17'h0, addr};
          ewc_pkg::REG_DATA: next_prdata = {24'h0, wdata};
          ewc_pkg::REG_STATUS: next_prdata = {28'h0, locked, poll_ok, done, busy};
          ewc_pkg::REG_RDATA: next_prdata = {24'h0, rdata};
          default: begin
            next_prdata = ewc_pkg::REG_RESET;
            next_pslverr = 1'b1;
          end
        endcase
      end
    end
    unique case (state)
      SQ_IDLE: ;
      SQ_PREFIX: begin
        // Number of command steps before data
        unique case (op)
          ewc_pkg::OP_SET_LOCK, ewc_pkg::OP_LOCKED_WRITE: next_nsteps = 3'd3;
          ewc_pkg::OP_CLEAR_LOCK, ewc_pkg::OP_CHIP_ERASE,
          ewc_pkg::OP_NO_AUTOERASE: next_nsteps = 3'd6;
          default: next_nsteps = 3'd0;
        endcase
        if (op == ewc_pkg::OP_READ || op == ewc_pkg::OP_POLL) begin
          next_state = (op == ewc_pkg::OP_POLL) ? SQ_WAIT_DELAY : SQ_READ;
          next_dly = (op == ewc_pkg::OP_POLL) ? POLL_DELAY : 32'h0;
          next_wr = 1'b0;
        end else if (op == ewc_pkg::OP_CHIP_ERASE && autoerase_off) begin
          next_busy = 1'b0; // see RULE18
          next_done = 1'b1;
          next_state = SQ_IDLE;
        end else if (op == ewc_pkg::OP_WRITE) begin
          next_state = SQ_DATA;
        end else if (!bus.req && !req && step < next_nsteps && !(step != 3'd0 && !bus.done)) begin
          // Steps go back to back inside the page load window, see RULE9
          next_req = 1'b1;
          next_wr = 1'b1;
          next_req_addr = pfx_addr;
          next_req_data = pfx_data;
          next_step = step + 3'd1;
        end else if (bus.done && step == next_nsteps) begin
          next_last_addr = ewc_pkg::ADDR_CMD_A;
          next_last_data = req_data;
          if (op == ewc_pkg::OP_SET_LOCK) next_locked = 1'b1; // see RULE13
          if (op == ewc_pkg::OP_CLEAR_LOCK) next_locked = 1'b0; // see RULE15
          if (op == ewc_pkg::OP_NO_AUTOERASE) next_autoerase_off = 1'b1;
          // Erase and set/clear need no data load, see RULE16
          if (op == ewc_pkg::OP_CHIP_ERASE || !last_data_needed(op)) begin
            next_busy = 1'b0;
            next_done = 1'b1;
            next_state = SQ_IDLE;
          end else begin
            next_state = SQ_DATA;
          end
        end
      end
      SQ_DATA: begin
        // Locked plain writes must go through the unlock, see RULE11
        if (op == ewc_pkg::OP_WRITE && locked) begin
          next_op = ewc_pkg::OP_LOCKED_WRITE;
          next_step = 3'd0;
          next_state = SQ_PREFIX;
        end else if (!req && !bus.req && !(bus.done && 1'b0)) begin
          next_req = 1'b1;
          next_wr = 1'b1;
          next_req_addr = addr;
          next_req_data = wdata;
          next_state = SQ_READ;
          next_dly = 32'h0;
        end
      end
      SQ_WAIT_DELAY: begin
        if (dly == 32'h0) begin
          next_req = 1'b1;
          next_wr = 1'b0;
          next_req_addr = last_addr;
          next_state = SQ_POLL;
        end else begin
          next_dly = dly - 32'h1; // see RULE3
        end
      end
      SQ_POLL: begin
        if (bus.done) begin
          next_rdata = bus.rdata;
          next_prev_b6 = bus.rdata[6];
          // True data and steady bit six mean the write ended, see RULE1, RULE2, RULE5
          next_poll_ok = (bus.rdata[7] == last_data[7]) && (bus.rdata[6] == prev_b6);
          if (next_poll_ok) begin
            next_autoerase_off = 1'b0; // see RULE19
          end
          next_busy = 1'b0;
          next_done = 1'b1;
          next_state = SQ_IDLE;
        end
      end
      SQ_READ: begin
        if (wr && bus.done) begin
          // Page byte loaded; last byte lets the window expire, see RULE21
          next_last_addr = req_addr;
          next_last_data = req_data;
          next_poll_ok = 1'b0;
          next_busy = 1'b0;
          next_done = 1'b1;
          next_state = SQ_IDLE;
        end else if (!wr && !req && !bus.req && dly == 32'h0) begin
          next_req = 1'b1;
          next_req_addr = addr; // see RULE10
          next_dly = 32'h1;
        end else if (!wr && bus.done) begin
          next_rdata = bus.rdata; // see RULE4
          next_busy = 1'b0;
          next_done = 1'b1;
          next_state = SQ_IDLE;
        end
      end
      default: next_state = SQ_IDLE;
    endcase
  end

  function automatic logic last_data_needed(input ewc_pkg::ewc_op_t o);
    last_data_needed = (o == ewc_pkg::OP_LOCKED_WRITE) || (o == ewc_pkg::OP_NO_AUTOERASE);
  endfunction

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      state <= SQ_IDLE;
      op <= ewc_pkg::OP_READ;
      step <= 3'd0;
      nsteps <= 3'd0;
      dly <= 32'h0;
      addr <= 15'h0000;
      wdata <= 8'h00;
      last_addr <= 15'h0000;
      last_data <= 8'h00;
      rdata <= 8'h00;
      busy <= 1'b0;
      done <= 1'b0;
      poll_ok <= 1'b0;
      locked <= 1'b0; // see RULE7
      autoerase_off <= 1'b0; // see RULE20
      prev_b6 <= 1'b0;
      req <= 1'b0;
      wr <= 1'b0;
      req_addr <= 15'h0000;
      req_data <= 8'h00;
      prdata_r <= ewc_pkg::REG_RESET;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      state <= next_state;
      op <= next_op;
      step <= next_step;
      nsteps <= next_nsteps;
      dly <= next_dly;
      addr <= next_addr;
      wdata <= next_wdata;
      last_addr <= next_last_addr;
      last_data <= next_last_data;
      rdata <= next_rdata;
      busy <= next_busy;
      done <= next_done;
      poll_ok <= next_poll_ok;
      locked <= next_locked;
      autoerase_off <= next_autoerase_off;
      prev_b6 <= next_prev_b6;
      req <= next_req;
      wr <= next_wr;
      req_addr <= next_req_addr;
      req_data <= next_req_data;
      prdata_r <= next_prdata;
      pready_r <= next_pready;
      pslverr_r <= next_pslverr;
    end
  end

  // Page address bits are software's to keep constant, see RULE22
  assign bus.req = req;
  assign bus.wr = wr;
  assign bus.addr = req_addr;
  assign bus.wdata = req_data;
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
endmodule

// [bench/ewc_checker.sv]
// Purpose: Port assertions for the EEPROM write controller
// Assumes: One clock, synchronous active-high reset
// Notes: Bound to ewc_ctrl after the module
`timescale 1ns/1ps
module ewc_checker (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic o_ce_n,
  input wire logic o_oe_n,
  input wire logic o_we_n,
  input wire logic [14:0] o_addr,
  input wire logic [7:0] o_dq,
  input wire logic o_dq_oe
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  a_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready not one cycle after access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_write_combo: assert property (!o_we_n |-> !o_ce_n && o_oe_n)
    else $error("write strobe outside byte-write combination");
  a_read_combo: assert property (!o_oe_n |-> o_we_n && !o_ce_n && !o_dq_oe)
    else $error("read strobe with bad combination");
  a_strobe_len: assert property ($fell(o_we_n) |-> (!o_we_n) [*5] ##1 o_we_n)
    else $error("write strobe length wrong");
  a_ce_after_we: assert property ($rose(o_we_n) |-> !o_ce_n && o_dq_oe ##1 o_ce_n && !o_dq_oe)
    else $error("select release order wrong");
  a_load_stable: assert property (!o_we_n && !$fell(o_we_n) |-> $stable(o_addr) && $stable(o_dq))
    else $error("address or data moved during strobe");
  a_dq_driven: assert property (!o_we_n |-> o_dq_oe)
    else $error("data not driven during write strobe");
endmodule

bind ewc_ctrl ewc_checker u_chk (.i_mclk(i_mclk), .i_rst(i_rst), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .o_ce_n(o_ce_n),
  .o_oe_n(o_oe_n), .o_we_n(o_we_n), .o_addr(o_addr), .o_dq(o_dq), .o_dq_oe(o_dq_oe));

// [bench/ewc_dev_model.sv]
// Purpose: Behavioural 32K x 8 EEPROM with lock, erase and polling
// Assumes: Pins sampled on i_mclk; times shortened to cycles
// Notes: Released data lines show the inverse of the last value
`timescale 1ns/1ps
module ewc_dev_model #(
  parameter int PLW = 80,
  parameter int WT = 150
) (
  input wire logic i_mclk,
  input wire logic i_ce_n,
  input wire logic i_oe_n,
  input wire logic i_we_n,
  input wire logic [14:0] i_addr,
  input wire logic [7:0] i_dq,
  output logic [7:0] o_dq = 8'h00
);
  logic [7:0] mem [logic [14:0]];
  logic [22:0] ld [$];
  logic we_q = 1'b1, oe_q = 1'b1, tog = 1'b0;
  logic locked = 1'b0;
  logic ae = 1'b1;
  logic [7:0] last = 8'h00;
  int tmr = 0, busy = 0;
  function automatic logic [7:0] rd(input logic [14:0] a);
    return mem.exists(a) ? mem[a] : 8'hff;
  endfunction
  function automatic bit step_is(int i, logic [14:0] a, logic [7:0] d);
    return ld.size() > i && ld[i] === {a, d};
  endfunction
  // Decode a finished page load as command steps plus data
  task automatic commit();
    int n;
    bit unl;
    n = 0;
    unl = step_is(0, 15'h5555, 8'haa) && step_is(1, 15'h2aaa, 8'h55);
    if (unl && step_is(2, 15'h5555, 8'ha0)) begin
      n = 3;
      locked = 1'b1;
    end else if (unl && step_is(2, 15'h5555, 8'h80) && step_is(3, 15'h5555, 8'haa)
                 && step_is(4, 15'h2aaa, 8'h55)) begin
      n = 6;
      if (step_is(5, 15'h5555, 8'h20)) locked = 1'b0;
      else if (step_is(5, 15'h5555, 8'h10) && ae) mem.delete();
      else if (step_is(5, 15'h5555, 8'h40)) ae = 1'b0;
      else n = 0;
    end else if (locked) begin
      n = ld.size();
    end
    for (int i = n; i < ld.size(); i++)
      mem[ld[i][22:8]] = ae ? ld[i][7:0] : rd(ld[i][22:8]) & ld[i][7:0];
    ld.delete();
    busy = WT;
  endtask
  always @(posedge i_mclk) begin
    if (busy == 1) ae = 1'b1;
    if (busy > 0) begin
      busy--;
    end else if (i_we_n && !we_q && !i_ce_n && i_oe_n) begin
      ld.push_back({i_addr, i_dq});
      last = i_dq;
      tmr = 0;
    end else if (ld.size() > 0 && i_we_n) begin
      tmr++;
      if (tmr >= PLW) commit();
    end
    if (!i_oe_n && oe_q) tog = ~tog;
    if (i_ce_n || i_oe_n) o_dq <= ~o_dq;
    else if (busy > 0 || ld.size() > 0) o_dq <= {~last[7], tog, last[5:0]};
    else o_dq <= rd(i_addr);
    we_q = i_we_n;
    oe_q = i_oe_n;
  end
endmodule

// [bench/ewc_ctrl_bench.sv]
// Purpose: Self-checking bench for ewc_ctrl against a device model
// Assumes: APB slave answers after one wait state
// Notes: Model page window and write time are shortened
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; \
  $display("mismatch at %0t: got %h expected %h", $time, (a), (b)); end end
module ewc_ctrl_bench;
  localparam int PLW = 80;
  localparam int WT = 150;
  logic i_mclk = 1'b0, i_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, perr, ce_n, oe_n, we_n, dq_oe;
  logic [14:0] dev_addr, a;
  logic [7:0] dq_out, dq_in, d, prev;
  logic [7:0] ref_mem [logic [14:0]];
  int err_total = 0, cmp_count = 0, cyc = 0, n;
  ewc_ctrl #(.POLL_DELAY(2)) DUT (.i_mclk(i_mclk), .i_rst(i_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .o_ce_n(ce_n), .o_oe_n(oe_n), .o_we_n(we_n),
    .o_addr(dev_addr), .o_dq(dq_out), .o_dq_oe(dq_oe), .i_dq(dq_in));
  ewc_dev_model #(.PLW(PLW), .WT(WT)) u_dev (.i_mclk(i_mclk), .i_ce_n(ce_n),
    .i_oe_n(oe_n), .i_we_n(we_n), .i_addr(dev_addr), .i_dq(dq_out), .o_dq(dq_in));
  always #12.5 i_mclk = ~i_mclk;
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc > 60000) begin
      err_total++;
      finish_test();
    end
  end
  function automatic logic [7:0] exp_rd(input logic [14:0] x);
    return ref_mem.exists(x) ? ref_mem[x] : 8'hff;
  endfunction
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge i_mclk);
    penable <= 1'b1;
    do @(posedge i_mclk); while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge i_mclk);
  endtask
  task automatic op(input logic [2:0] code, input logic [14:0] x, input logic [7:0] v,
                    input logic lst);
    apb(1'b1, ewc_pkg::REG_ADDR, {17'h0, x});
    apb(1'b1, ewc_pkg::REG_DATA, {24'h0, v});
    apb(1'b1, ewc_pkg::REG_CTRL, {27'h0, lst, code, 1'b1});
    do apb(1'b0, ewc_pkg::REG_STATUS, 32'h0); while (rd[ewc_pkg::ST_DONE] !== 1'b1);
    apb(1'b1, ewc_pkg::REG_STATUS, 32'h1 << ewc_pkg::ST_DONE);
  endtask
  task automatic dev_read(input logic [14:0] x);
    op(ewc_pkg::OP_READ, x, 8'h00, 1'b1);
    apb(1'b0, ewc_pkg::REG_RDATA, 32'h0);
  endtask
  task automatic poll_wait();
    n = 0;
    do begin
      op(ewc_pkg::OP_POLL, a, 8'h00, 1'b1);
      apb(1'b0, ewc_pkg::REG_STATUS, 32'h0);
      n++;
    end while (rd[ewc_pkg::ST_POLL_OK] !== 1'b1 && n < 20);
    `CHK(rd[ewc_pkg::ST_POLL_OK], 1'b1)
  endtask
  task automatic settle();
    repeat (PLW + WT + 20) @(posedge i_mclk);
  endtask
  task automatic lock_state(input logic want);
    settle();
    apb(1'b0, ewc_pkg::REG_STATUS, 32'h0);
    `CHK(rd[ewc_pkg::ST_LOCKED], want)
    `CHK(u_dev.locked, want)
  endtask
  initial begin
    void'($urandom(32'h4107c48b));
    repeat (6) @(posedge i_mclk);
    i_rst <= 1'b0;
    @(posedge i_mclk);
    apb(1'b0, ewc_pkg::REG_STATUS, 32'h0);
    `CHK(rd, ewc_pkg::REG_RESET)
    apb(1'b0, 8'h40, 32'h0);
    `CHK({perr, rd}, {1'b1, 32'h0})
    $display("test reset done");
    repeat (2) begin
      a = 15'($urandom());
      for (int i = 0; i < 4; i++) begin
        d = 8'($urandom());
        ref_mem[{a[14:6], 6'(i * 9)}] = d;
        op(ewc_pkg::OP_WRITE, {a[14:6], 6'(i * 9)}, d, i == 3);
      end
      dev_read(a ^ 15'h0100);
      `CHK(rd[7], ~d[7])
      prev = rd[7:0];
      dev_read(a);
      `CHK(rd[6], ~prev[6])
      poll_wait();
      for (int i = 0; i < 4; i++) begin
        dev_read({a[14:6], 6'(i * 9)});
        `CHK(rd[7:0], exp_rd({a[14:6], 6'(i * 9)}))
      end
    end
    $display("test page write done");
    op(ewc_pkg::OP_SET_LOCK, 15'h0, 8'h00, 1'b1);
    lock_state(1'b1);
    a = 15'($urandom());
    d = 8'($urandom());
    ref_mem[a] = d;
    op(ewc_pkg::OP_LOCKED_WRITE, a, d, 1'b1);
    lock_state(1'b1);
    dev_read(a);
    `CHK(rd[7:0], d)
    $display("test lock done");
    op(ewc_pkg::OP_NO_AUTOERASE, 15'h0, 8'h00, 1'b1);
    ref_mem[15'h0] = 8'h00;
    settle();
    `CHK(u_dev.ae, 1'b1)
    // Erase refused until a poll sees the write end
    op(ewc_pkg::OP_CHIP_ERASE, 15'h0, 8'h00, 1'b1);
    dev_read(a);
    `CHK(rd[7:0], exp_rd(a))
    poll_wait();
    op(ewc_pkg::OP_CHIP_ERASE, 15'h0, 8'h00, 1'b1);
    settle();
    ref_mem.delete();
    dev_read(a);
    `CHK(rd[7:0], exp_rd(a))
    $display("test erase done");
    op(ewc_pkg::OP_CLEAR_LOCK, 15'h0, 8'h00, 1'b1);
    lock_state(1'b0);
    d = ~d;
    op(ewc_pkg::OP_WRITE, a, d, 1'b1);
    settle();
    dev_read(a);
    `CHK(rd[7:0], d)
    $display("test unlock done");
    finish_test();
  end
endmodule
